// File: interrupt_request_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module interrupt_request_logic_tb;
   // ****************************************************************
   // Signals
   // ****************************************************************
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic ext_irq_pin = 1'b0;
   logic portb_change_pin = 1'b0;
   logic timer_zero_ovf = 1'b0;
   logic [7:0] periph_evt_a = 8'h00;
   logic [7:0] periph_evt_b = 8'h00;
   logic [4:0] wr = 5'h00;
   logic [7:0] wd = 8'h00;
   logic ret_cmd = 1'b0;
   logic return_from_irq_instr, irq_request, vector_load, stack_push, cycle_en;
   logic [12:0] core_pc, vector_pc, stack_addr;
   logic [7:0] irq_control_reg, periph_flag_reg_a, periph_flag_reg_b;
   logic [7:0] periph_mask_reg_a, periph_mask_reg_b;
   int num_errors = 0;
   int n_checks = 0;
   irl_top uut (.mclk, .reset_n, .ext_irq_pin, .portb_change_pin, .timer_zero_ovf,
      .periph_evt_a, .periph_evt_b, .ctl_wr(wr[0]), .ctl_wdata(wd), .flag_a_wr(wr[1]),
      .flag_a_wdata(wd), .flag_b_wr(wr[2]), .flag_b_wdata(wd), .mask_a_wr(wr[3]),
      .mask_a_wdata(wd), .mask_b_wr(wr[4]), .mask_b_wdata(wd), .return_from_irq_instr,
      .core_pc, .irq_control_reg, .periph_flag_reg_a, .periph_flag_reg_b,
      .periph_mask_reg_a, .periph_mask_reg_b, .irq_request, .vector_load, .vector_pc,
      .stack_push, .stack_addr, .cycle_en);
   irl_core_model u_core (.mclk, .reset_n, .cycle_en, .vector_load, .ret_cmd, .core_pc,
      .return_from_irq_instr);
   initial begin
      forever #5 mclk = ~mclk;
   end
   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic print_verdict();
      if (num_errors == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Select 0 control, 1 flag a, 2 flag b, 3 mask a, 4 mask b
   task automatic wreg(input int sel, input logic [7:0] d);
      @(negedge mclk);
      wr = 5'h01 << sel;
      wd = d;
      @(negedge mclk);
      wr = 5'h00;
   endtask
   task automatic wait_vec(output int n);
      n = 0;
      repeat (60) begin
         @(posedge mclk);
         #1;
         if (cycle_en) n++;
         if (vector_load) break;
      end
   endtask
   // Sixteen clocks with neither a request nor a vector
   task automatic quiet(input string what);
      int s;
      s = 0;
      repeat (16) begin
         @(posedge mclk);
         #1;
         s += irq_request | vector_load;
      end
      chk(what, 13'h0000, s[12:0]);
   endtask
   task automatic do_return();
      @(negedge mclk);
      ret_cmd = 1'b1;
      @(negedge mclk);
      ret_cmd = 1'b0;
      repeat (3) @(negedge mclk);
      chk("global enable", 13'h0001, irq_control_reg[7]);
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      chk("control", 13'h0000, irq_control_reg);
      chk("irq_request", 13'h0000, irq_request);
   endtask
   task automatic t_flags();
      @(negedge mclk);
      timer_zero_ovf = 1'b1;
      periph_evt_a = 8'hA5;
      periph_evt_b = 8'h3C;
      @(negedge mclk);
      timer_zero_ovf = 1'b0;
      periph_evt_a = 8'h00;
      periph_evt_b = 8'h00;
      @(negedge mclk);
      chk("control", 13'h0004, irq_control_reg);
      chk("flags a", 13'h00A5, periph_flag_reg_a);
      chk("flags b", 13'h003C, periph_flag_reg_b);
      quiet("disabled request");
   endtask
   task automatic t_mask();
      int n;
      wreg(3, 8'h5A);
      chk("mask a", 13'h005A, periph_mask_reg_a);
      wreg(0, 8'hE0);
      quiet("masked request");
      wreg(0, 8'hA0);
      wreg(4, 8'h04);
      chk("mask b", 13'h0004, periph_mask_reg_b);
      quiet("group disabled request");
      wreg(0, 8'hC0);
      @(posedge mclk);
      #1;
      chk("irq_request", 13'h0001, irq_request);
      wait_vec(n);
      chk("vector_load", 13'h0001, vector_load);
      chk("vector_pc", 13'h0004, vector_pc);
      chk("global enable", 13'h0000, irq_control_reg[7]);
      wreg(2, 8'h00);
      do_return();
      quiet("after return");
   endtask
   task automatic t_ext();
      int n;
      for (int i = 0; i < 4; i++) begin
         wreg(0, i[0] ? 8'h88 : 8'h90);
         repeat (i) @(negedge mclk);
         if (i[0]) portb_change_pin = 1'b1;
         else ext_irq_pin = 1'b1;
         wait_vec(n);
         chk("vector_load", 13'h0001, vector_load);
         chk("latency in range", 13'h0001, (n >= 3 && n <= 4));
         chk("pin flag", 13'h0001, i[0] ? irq_control_reg[0] : irq_control_reg[1]);
         @(negedge mclk);
         ext_irq_pin = 1'b0;
         portb_change_pin = 1'b0;
         wreg(0, 8'h00);
         do_return();
      end
   endtask
   initial begin
      repeat (6) @(negedge mclk);
      reset_n = 1'b1;
      repeat (3) @(negedge mclk);
      t_reset();
      t_flags();
      t_mask();
      t_ext();
      print_verdict();
   end
   initial begin
      #20us;
      num_errors++;
      print_verdict();
   end
endmodule
`default_nettype wire

// File: irl_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module irl_core_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // From the interrupt logic
   input wire logic cycle_en,
   input wire logic vector_load,
   // Bench command and core outputs
   input wire logic ret_cmd,
   output logic [12:0] core_pc,
   output logic return_from_irq_instr
);
   // ****************************************************************
   // Sequencer
   // ****************************************************************
   logic ret_q;
   // Sampled on the rising edge, driven on the falling one, so no race
   always @(posedge mclk) ret_q <= ret_cmd;
   always @(negedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         core_pc <= 13'h0100;
         return_from_irq_instr <= 1'b0;
      end else begin
         return_from_irq_instr <= ret_q;
         if (vector_load) core_pc <= 13'h0004;
         else if (cycle_en) core_pc <= core_pc + 13'h0001;
      end
   end
endmodule
`default_nettype wire

// File: irl_cycle_div.sv
`timescale 1ns/1ps
`default_nettype none
module irl_cycle_div #(
   parameter int DIV = 4
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // One pulse per instruction cycle
   output logic cyc_en
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   if (DIV < 1) begin : g_bad_div
      $error("DIV must be at least 1");
   end
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic en_next;

   always_comb begin
      en_next = (cnt_reg == CW'(DIV - 1));
      cnt_next = en_next ? '0 : cnt_reg + 1'b1;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= '0;
         cyc_en <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         cyc_en <= en_next;
      end
   end
endmodule
`default_nettype wire

// File: irl_pkg.sv
package irl_pkg;
   // ****************************************************************
   // Control register layout
   // ****************************************************************
   localparam int CTL_GIE_BIT = 7;
   localparam int CTL_PEIE_BIT = 6;
   localparam int CTL_T0IE_BIT = 5;
   localparam int CTL_INTE_BIT = 4;
   localparam int CTL_RBIE_BIT = 3;
   localparam int CTL_T0IF_BIT = 2;
   localparam int CTL_INTF_BIT = 1;
   localparam int CTL_RBIF_BIT = 0;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] PERIPH_RESET = 8'h00;
   // ****************************************************************
   // Vectoring and timing
   // ****************************************************************
   localparam logic [12:0] IRQ_VECTOR = 13'h0004;
   localparam int SRC_COUNT = 11;
   localparam int CORE_SRC_COUNT = 3;
   localparam int PERIPH_SRC_COUNT = SRC_COUNT - CORE_SRC_COUNT;
   localparam int CLK_PER_INSTR = 4;
   localparam int LAT_MIN_INSTR = 3;
   localparam int LAT_MAX_INSTR = 4;
   // Instruction cycles from acceptance to the vector; the pin synchroniser
   // and the wait for a cycle boundary make up the rest of the latency
   localparam int PIPE_INSTR = LAT_MIN_INSTR - 2;
   typedef enum logic [2:0] {
      IRL_IDLE = 3'b001,
      IRL_WAIT = 3'b010,
      IRL_VEC = 3'b100
   } irl_state_t;
endpackage

// File: irl_sync.sv
`timescale 1ns/1ps
`default_nettype none
module irl_sync (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Asynchronous level in, one-cycle rising pulse out
   input wire logic async_in,
   output logic rise_pulse
);
   logic [2:0] sh_reg;
   logic [2:0] sh_next;
   logic level_reg;
   logic level_next;
   logic rise_next;

   always_comb begin
      sh_next = {sh_reg[1:0], async_in};
      level_next = level_reg;
      // Accept a change only once stages two and three agree
      if (sh_reg[1] == sh_reg[2]) begin
         level_next = sh_reg[2];
      end
      rise_next = level_next & ~level_reg;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sh_reg <= 3'h0;
         level_reg <= 1'b0;
         rise_pulse <= 1'b0;
      end else begin
         sh_reg <= sh_next;
         level_reg <= level_next;
         rise_pulse <= rise_next;
      end
   end
endmodule
`default_nettype wire

// File: irl_top.sv
`timescale 1ns/1ps
`default_nettype none
module irl_top #(
   parameter int PC_W = 13
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // External event pins, asynchronous
   input wire logic ext_irq_pin,
   input wire logic portb_change_pin,
   // Internal events, one-cycle pulses on mclk
   input wire logic timer_zero_ovf,
   input wire logic [irl_pkg::PERIPH_SRC_COUNT-1:0] periph_evt_a,
   input wire logic [irl_pkg::PERIPH_SRC_COUNT-1:0] periph_evt_b,
   // Core register writes
   input wire logic ctl_wr,
   input wire logic [7:0] ctl_wdata,
   input wire logic flag_a_wr,
   input wire logic [7:0] flag_a_wdata,
   input wire logic flag_b_wr,
   input wire logic [7:0] flag_b_wdata,
   input wire logic mask_a_wr,
   input wire logic [7:0] mask_a_wdata,
   input wire logic mask_b_wr,
   input wire logic [7:0] mask_b_wdata,
   // Core sequencer
   input wire logic return_from_irq_instr,
   input wire logic [PC_W-1:0] core_pc,
   // Register views
   output logic [7:0] irq_control_reg,
   output logic [7:0] periph_flag_reg_a,
   output logic [7:0] periph_flag_reg_b,
   output logic [7:0] periph_mask_reg_a,
   output logic [7:0] periph_mask_reg_b,
   // Vectoring
   output logic irq_request,
   output logic vector_load,
   output logic [PC_W-1:0] vector_pc,
   output logic stack_push,
   output logic [PC_W-1:0] stack_addr,
   output logic cycle_en
);
   // Elaboration checks: the vector must fit the counter, and the flag
   // registers hold three control sources plus two peripheral bytes at most
   if (PC_W < 13) begin : g_bad_pc_w
      $error("PC_W must hold the vector address");
   end
   if (irl_pkg::SRC_COUNT > irl_pkg::CORE_SRC_COUNT + 16) begin : g_bad_src
      $error("too many sources");
   end
   if (irl_pkg::PERIPH_SRC_COUNT != 8) begin : g_bad_periph
      $error("peripheral event ports must match the flag registers");
   end

   // ****************************************************************
   // Reset release and instruction cycle
   // ****************************************************************
   logic [1:0] rst_sh_reg;
   logic rst_n;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sh_reg <= 2'h0;
      end else begin
         rst_sh_reg <= {rst_sh_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sh_reg[1];

   logic cyc;
   irl_cycle_div #(.DIV(irl_pkg::CLK_PER_INSTR)) u_div (
      .mclk(mclk),
      .rst_n(rst_n),
      .cyc_en(cyc)
   );

   // ****************************************************************
   // External event synchronisers
   // ****************************************************************
   logic ext_rise;
   logic rbc_rise;
   irl_sync u_sync_ext (
      .mclk(mclk),
      .rst_n(rst_n),
      .async_in(ext_irq_pin),
      .rise_pulse(ext_rise)
   );
   irl_sync u_sync_rbc (
      .mclk(mclk),
      .rst_n(rst_n),
      .async_in(portb_change_pin),
      .rise_pulse(rbc_rise)
   );

   // ****************************************************************
   // Flag and mask registers
   // ****************************************************************
   logic [7:0] ctl_reg;
   logic [7:0] ctl_next;
   logic [7:0] fa_reg;
   logic [7:0] fa_next;
   logic [7:0] fb_reg;
   logic [7:0] fb_next;
   logic [7:0] ma_reg;
   logic [7:0] ma_next;
   logic [7:0] mb_reg;
   logic [7:0] mb_next;
   logic accept;
   logic req_next;

   // Software write first, then hardware sets, so an event never gets lost
   function automatic logic [7:0] flag_upd(input logic [7:0] cur, input logic wr,
                                           input logic [7:0] wd, input logic [7:0] ev);
      logic [7:0] v;
      v = wr ? wd : cur;
      return v | ev;
   endfunction

   always_comb begin
      ctl_next = ctl_reg;
      if (ctl_wr) begin
         ctl_next = ctl_wdata;
      end
      // Sources set their flags independently of any enable
      ctl_next[irl_pkg::CTL_INTF_BIT] = ctl_next[irl_pkg::CTL_INTF_BIT] | ext_rise;
      ctl_next[irl_pkg::CTL_RBIF_BIT] = ctl_next[irl_pkg::CTL_RBIF_BIT] | rbc_rise;
      ctl_next[irl_pkg::CTL_T0IF_BIT] =
         ctl_next[irl_pkg::CTL_T0IF_BIT] | timer_zero_ovf;
      // Acceptance wins over a same-cycle software set of the enable
      if (return_from_irq_instr) begin
         ctl_next[irl_pkg::CTL_GIE_BIT] = 1'b1;
      end
      if (accept) begin
         ctl_next[irl_pkg::CTL_GIE_BIT] = 1'b0;
      end
      fa_next = flag_upd(fa_reg, flag_a_wr, flag_a_wdata, periph_evt_a);
      fb_next = flag_upd(fb_reg, flag_b_wr, flag_b_wdata, periph_evt_b);
      ma_next = mask_a_wr ? mask_a_wdata : ma_reg;
      mb_next = mask_b_wr ? mask_b_wdata : mb_reg;
   end

   // ****************************************************************
   // Request combine
   // ****************************************************************
   logic core_pend;
   logic periph_pend;
   always_comb begin
      core_pend = (ctl_reg[irl_pkg::CTL_T0IE_BIT] & ctl_reg[irl_pkg::CTL_T0IF_BIT])
                | (ctl_reg[irl_pkg::CTL_INTE_BIT] & ctl_reg[irl_pkg::CTL_INTF_BIT])
                | (ctl_reg[irl_pkg::CTL_RBIE_BIT] & ctl_reg[irl_pkg::CTL_RBIF_BIT]);
      periph_pend = ctl_reg[irl_pkg::CTL_PEIE_BIT]
                  & (|(fa_reg & ma_reg) | |(fb_reg & mb_reg));
      req_next = ctl_reg[irl_pkg::CTL_GIE_BIT] & (core_pend | periph_pend);
   end

   // ****************************************************************
   // Acceptance sequencer
   // ****************************************************************
   // Request is sampled at instruction-cycle boundaries only and the wait is a
   // fixed count, so the instruction length cannot change the latency.
   irl_pkg::irl_state_t st_reg;
   irl_pkg::irl_state_t st_next;
   logic [1:0] wait_reg;
   logic [1:0] wait_next;
   logic vec_next;
   logic [PC_W-1:0] stk_next;
   logic [PC_W-1:0] stk_reg;

   always_comb begin
      st_next = st_reg;
      wait_next = wait_reg;
      accept = 1'b0;
      vec_next = 1'b0;
      stk_next = stk_reg;
      case (st_reg)
         irl_pkg::IRL_IDLE: begin
            if (cyc && req_next) begin
               st_next = irl_pkg::IRL_WAIT;
               wait_next = 2'(irl_pkg::PIPE_INSTR - 1);
               accept = 1'b1;
               stk_next = core_pc;
            end
         end
         irl_pkg::IRL_WAIT: begin
            if (cyc) begin
               if (wait_reg == 2'h0) begin
                  st_next = irl_pkg::IRL_VEC;
               end else begin
                  wait_next = wait_reg - 2'h1;
               end
            end
         end
         irl_pkg::IRL_VEC: begin
            vec_next = 1'b1;
            st_next = irl_pkg::IRL_IDLE;
         end
         default: begin
            st_next = irl_pkg::IRL_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_reg <= irl_pkg::CTL_RESET;
         fa_reg <= irl_pkg::PERIPH_RESET;
         fb_reg <= irl_pkg::PERIPH_RESET;
         ma_reg <= irl_pkg::PERIPH_RESET;
         mb_reg <= irl_pkg::PERIPH_RESET;
         st_reg <= irl_pkg::IRL_IDLE;
         wait_reg <= 2'h0;
         stk_reg <= '0;
      end else begin
         ctl_reg <= ctl_next;
         fa_reg <= fa_next;
         fb_reg <= fb_next;
         ma_reg <= ma_next;
         mb_reg <= mb_next;
         st_reg <= st_next;
         wait_reg <= wait_next;
         stk_reg <= stk_next;
      end
   end

   // ****************************************************************
   // Registered outputs
   // ****************************************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_control_reg <= irl_pkg::CTL_RESET;
         periph_flag_reg_a <= irl_pkg::PERIPH_RESET;
         periph_flag_reg_b <= irl_pkg::PERIPH_RESET;
         periph_mask_reg_a <= irl_pkg::PERIPH_RESET;
         periph_mask_reg_b <= irl_pkg::PERIPH_RESET;
         irq_request <= 1'b0;
         vector_load <= 1'b0;
         vector_pc <= '0;
         stack_push <= 1'b0;
         stack_addr <= '0;
         cycle_en <= 1'b0;
      end else begin
         irq_control_reg <= ctl_next;
         periph_flag_reg_a <= fa_next;
         periph_flag_reg_b <= fb_next;
         periph_mask_reg_a <= ma_next;
         periph_mask_reg_b <= mb_next;
         irq_request <= req_next;
         vector_load <= vec_next;
         vector_pc <= PC_W'(irl_pkg::IRQ_VECTOR);
         stack_push <= accept;
         stack_addr <= accept ? core_pc : stk_reg;
         cycle_en <= cyc;
      end
   end
endmodule
`default_nettype wire

// File: irl_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module irl_top_chk #(
   parameter int PC_W = 13
) (
   // Watched ports
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic timer_zero_ovf,
   input wire logic [irl_pkg::PERIPH_SRC_COUNT-1:0] periph_evt_a,
   input wire logic return_from_irq_instr,
   input wire logic [PC_W-1:0] core_pc,
   input wire logic [7:0] irq_control_reg,
   input wire logic [7:0] periph_flag_reg_a,
   input wire logic irq_request,
   input wire logic vector_load,
   input wire logic [PC_W-1:0] vector_pc,
   input wire logic stack_push,
   input wire logic [PC_W-1:0] stack_addr,
   input wire logic cycle_en
);
   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   sequence s_vec;
      ##5 vector_load;
   endsequence
   property p_t0_flag; timer_zero_ovf |=> irq_control_reg[2]; endproperty
   a_t0_flag: assert property (p_t0_flag) else $error("timer flag not set");
   property p_pflag;
      (|periph_evt_a) |=> ((periph_flag_reg_a & $past(periph_evt_a)) == $past(periph_evt_a));
   endproperty
   a_pflag: assert property (p_pflag) else $error("peripheral flag not set");
   property p_gate;
      !irq_control_reg[7] && !$past(irq_control_reg[7]) |-> !irq_request;
   endproperty
   a_gate: assert property (p_gate) else $error("request while disabled");
   property p_push_gie; stack_push |-> !irq_control_reg[7]; endproperty
   a_push_gie: assert property (p_push_gie) else $error("enable kept on accept");
   property p_push_vec; stack_push |-> s_vec; endproperty
   a_push_vec: assert property (p_push_vec) else $error("no vector after accept");
   property p_addr; stack_push |-> stack_addr == $past(core_pc); endproperty
   a_addr: assert property (p_addr) else $error("wrong stacked address");
   property p_vpc; vector_load |-> vector_pc == 13'h0004; endproperty
   a_vpc: assert property (p_vpc) else $error("wrong vector");
   property p_ret;
      return_from_irq_instr ##1 !stack_push |-> irq_control_reg[7];
   endproperty
   a_ret: assert property (p_ret) else $error("return did not enable");
   property p_cyc; cycle_en |=> !cycle_en [*3] ##1 cycle_en; endproperty
   a_cyc: assert property (p_cyc) else $error("instruction cycle not four clocks");
endmodule
bind irl_top irl_top_chk #(.PC_W(PC_W)) u_chk (.mclk(mclk), .reset_n(reset_n),
   .timer_zero_ovf(timer_zero_ovf), .periph_evt_a(periph_evt_a),
   .return_from_irq_instr(return_from_irq_instr), .core_pc(core_pc),
   .irq_control_reg(irq_control_reg), .periph_flag_reg_a(periph_flag_reg_a),
   .irq_request(irq_request), .vector_load(vector_load), .vector_pc(vector_pc),
   .stack_push(stack_push), .stack_addr(stack_addr), .cycle_en(cycle_en));
`default_nettype wire
